// File: src/irq_pin_router.sv
// Purpose: routes audio and touch events to two irq outputs and muxes the multi-purpose pin
// Assumes: event inputs are one-cycle pulses and status levels from logic on mclk_i
// Notes: register reads return data one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none

module irq_pin_router
    import irq_router_pkg::*;
#(
    parameter int PULSE_CYCLES = PULSE_CYC,
    parameter int PERIOD_CYCLES = PERIOD_CYC
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic ev_headset_insert_i,
    input wire logic ev_button_press_i,
    input wire logic ev_drc_power_i,
    input wire logic ev_agc_noise_i,
    input wire logic ev_short_circuit_i,
    input wire logic ev_engine_i,
    input wire logic ev_dc_meas_ready_i,
    input wire logic ev_out_of_range_i,
    input wire logic ev_touch_data_i,
    input wire logic pen_touch_i,
    input wire logic meas_data_ready_i,
    input wire logic meas_out_of_range_i,
    input wire logic divided_clock_output_i,
    input wire logic record_word_clock_i,
    input wire logic sec_bit_clock_i,
    input wire logic sec_word_clock_i,
    input wire logic microphone_modulator_clock_i,
    input wire logic sec_audio_serial_out_i,
    input wire logic touch_data_ready_irq_n_i,
    input wire logic multi_purpose_pin_in_i,
    output logic multi_purpose_pin_out_o,
    output logic multi_purpose_pin_oe_n_o,
    output logic pin_input_o,
    output logic general_purpose_input_o,
    output logic first_irq_output_o,
    output logic second_irq_output_o,
    output logic [NUM_EVENTS-1:0] sticky_flags_o
);

    localparam int CW = $clog2(PERIOD_CYCLES + 1);
    localparam logic [CW-1:0] PULSE_LAST = CW'(PULSE_CYCLES - 1);
    localparam logic [CW-1:0] PERIOD_LAST = CW'(PERIOD_CYCLES - 1);

    logic [7:0] sec_en_r;
    logic [3:0] comb_ctrl_r;
    logic [7:0] pin_ctrl_r;
    logic [7:0] rdata_r;
    logic pin_meta_r;
    logic pin_sync_r;
    logic pin_out_r;
    logic pin_oe_n_r;
    logic [NUM_EVENTS-1:0] sticky_r;
    logic [1:0] train_r;
    logic [2:0] seen_r [2];
    pulse_state_t pg_st_r [2];
    logic [CW-1:0] pg_cnt_r [2];

    logic [7:1] sec_ev;
    logic [1:0] trig;
    logic [1:0] mode;
    logic [2:0] flag_rd;
    logic wr_sec;
    logic wr_comb;
    logic wr_pin;
    pin_func_t pin_func;
    logic in_buf_on;

    assign wr_sec = reg_wr_i && (reg_addr_i == ADDR_SEC_EN);
    assign wr_comb = reg_wr_i && (reg_addr_i == ADDR_COMBINED);
    assign wr_pin = reg_wr_i && (reg_addr_i == ADDR_PIN_CTRL);
    assign flag_rd = {reg_rd_i && (reg_addr_i == ADDR_COMBINED),
                      reg_rd_i && (reg_addr_i == ADDR_FLAGS_B),
                      reg_rd_i && (reg_addr_i == ADDR_FLAGS_A)};

    // event vector lines up with the enable bits D7..D1
    assign sec_ev = {ev_headset_insert_i, ev_button_press_i, ev_drc_power_i, ev_agc_noise_i,
                     ev_short_circuit_i, ev_engine_i, ev_dc_meas_ready_i};

    // first output has no repeat control here, so it always gives a single pulse
    assign mode = {sec_en_r[SEC_MODE_BIT], 1'b0};

    always_comb begin
        trig[0] = (ev_out_of_range_i && comb_ctrl_r[COMB_RANGE1_BIT - COMB_CTRL_LSB])
                || (ev_touch_data_i && comb_ctrl_r[COMB_DATA1_BIT - COMB_CTRL_LSB]);
        trig[1] = (|(sec_ev & sec_en_r[7:1]))
                || (ev_out_of_range_i && comb_ctrl_r[COMB_RANGE2_BIT - COMB_CTRL_LSB]);
    end

    assign pin_func = pin_func_t'(pin_ctrl_r[PIN_FUNC_MSB:PIN_FUNC_LSB]);
    assign in_buf_on = (pin_func != PF_OFF);

    // registers
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            sec_en_r <= SEC_EN_RESET;
            comb_ctrl_r <= COMB_CTRL_RESET;
            pin_ctrl_r <= PIN_CTRL_RESET;
        end else begin
            if (wr_sec) begin
                sec_en_r <= reg_wdata_i;
            end
            if (wr_comb) begin
                comb_ctrl_r <= reg_wdata_i[7:COMB_CTRL_LSB];
            end
            if (wr_pin) begin
                // upper bits are stored as written; software keeps them at reset value
                pin_ctrl_r[7:PIN_FUNC_LSB] <= reg_wdata_i[7:PIN_FUNC_LSB];
                pin_ctrl_r[PIN_GPO_BIT] <= reg_wdata_i[PIN_GPO_BIT];
            end
        end
    end

    // read data, registered; unmapped addresses answer zero
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            rdata_r <= 8'h00;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                ADDR_SEC_EN: rdata_r <= sec_en_r;
                ADDR_COMBINED: rdata_r <= {comb_ctrl_r, pen_touch_i, meas_data_ready_i,
                                           meas_out_of_range_i, 1'b0};
                ADDR_PIN_CTRL: rdata_r <= {pin_ctrl_r[7:PIN_FUNC_LSB], in_buf_on && pin_sync_r,
                                           pin_ctrl_r[PIN_GPO_BIT]};
                default: rdata_r <= 8'h00;
            endcase
        end
    end

    // sticky copies of every event; a new event in the read cycle survives
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            sticky_r <= '0;
        end else begin
            sticky_r <= (sticky_r & ~{NUM_EVENTS{|flag_rd}})
                      | {ev_touch_data_i, ev_out_of_range_i, sec_ev};
        end
    end

    // repeat train runs until all three flag registers have been read since the last event
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            train_r <= 2'b00;
            seen_r[0] <= 3'b000;
            seen_r[1] <= 3'b000;
        end else begin
            for (int k = 0; k < 2; k++) begin
                if (trig[k]) begin
                    train_r[k] <= mode[k];
                    seen_r[k] <= 3'b000;
                end else begin
                    seen_r[k] <= seen_r[k] | flag_rd;
                    if (&(seen_r[k] | flag_rd)) begin
                        train_r[k] <= 1'b0;
                    end
                end
            end
        end
    end

    // pulse generators: 2 ms high, then low until the 4 ms period ends
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            for (int k = 0; k < 2; k++) begin
                pg_st_r[k] <= PG_IDLE;
                pg_cnt_r[k] <= '0;
            end
        end else begin
            for (int k = 0; k < 2; k++) begin
                unique case (pg_st_r[k])
                    PG_IDLE: begin
                        if (trig[k]) begin
                            pg_st_r[k] <= PG_HIGH;
                            pg_cnt_r[k] <= '0;
                        end
                    end
                    PG_HIGH: begin
                        pg_cnt_r[k] <= pg_cnt_r[k] + 1'b1;
                        if (pg_cnt_r[k] == PULSE_LAST) begin
                            // events landing inside a pulse merge into it
                            pg_st_r[k] <= (mode[k] && train_r[k]) ? PG_GAP : PG_IDLE;
                        end
                    end
                    PG_GAP: begin
                        pg_cnt_r[k] <= pg_cnt_r[k] + 1'b1;
                        if (pg_cnt_r[k] == PERIOD_LAST) begin
                            pg_cnt_r[k] <= '0;
                            pg_st_r[k] <= train_r[k] ? PG_HIGH : PG_IDLE;
                        end
                    end
                    default: begin
                        pg_st_r[k] <= PG_IDLE;
                        pg_cnt_r[k] <= '0;
                    end
                endcase
            end
        end
    end

    assign first_irq_output_o = (pg_st_r[0] == PG_HIGH);
    assign second_irq_output_o = (pg_st_r[1] == PG_HIGH);

    // pin input synchroniser
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            pin_meta_r <= 1'b0;
            pin_sync_r <= 1'b0;
        end else begin
            pin_meta_r <= multi_purpose_pin_in_i;
            pin_sync_r <= pin_meta_r;
        end
    end

    // pin output mux; reserved codes release the output like code 0000 but leave the input buffer on
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            pin_out_r <= 1'b0;
            pin_oe_n_r <= 1'b1;
        end else begin
            pin_oe_n_r <= 1'b0;
            unique case (pin_func)
                PF_GPO: pin_out_r <= pin_ctrl_r[PIN_GPO_BIT];
                PF_DIVIDED_CLOCK_OUTPUT: pin_out_r <= divided_clock_output_i;
                PF_IRQ1: pin_out_r <= first_irq_output_o;
                PF_IRQ2: pin_out_r <= second_irq_output_o;
                PF_REC_WCLK: pin_out_r <= record_word_clock_i;
                PF_SEC_BCLK: pin_out_r <= sec_bit_clock_i;
                PF_SEC_WCLK: pin_out_r <= sec_word_clock_i;
                PF_MIC_CLK: pin_out_r <= microphone_modulator_clock_i;
                PF_SEC_SOUT: pin_out_r <= sec_audio_serial_out_i;
                PF_TOUCH_IRQ: pin_out_r <= touch_data_ready_irq_n_i;
                default: begin
                    pin_out_r <= 1'b0;
                    pin_oe_n_r <= 1'b1;
                end
            endcase
        end
    end

    assign multi_purpose_pin_out_o = pin_out_r;
    assign multi_purpose_pin_oe_n_o = pin_oe_n_r;
    assign pin_input_o = (pin_func == PF_IN) && pin_sync_r;
    assign general_purpose_input_o = (pin_func == PF_GPI) && pin_sync_r;
    assign reg_rdata_o = rdata_r;
    assign sticky_flags_o = sticky_r;

    // checks
    chk_headset_gate: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (pg_st_r[1] == PG_IDLE && ev_headset_insert_i && sec_en_r[7]) |=> second_irq_output_o)
        else $error("enabled headset event did not start second irq");

    chk_no_cause_idle: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (pg_st_r[1] == PG_IDLE && !(|(sec_ev & sec_en_r[7:1]))
         && !(ev_out_of_range_i && comb_ctrl_r[COMB_RANGE2_BIT - COMB_CTRL_LSB]))
        |=> !second_irq_output_o)
        else $error("second irq started without an enabled event");

    chk_pulse_width: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        $fell(second_irq_output_o) |-> $past(pg_cnt_r[1]) == PULSE_LAST)
        else $error("second irq pulse length wrong");

    chk_single_ends: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (pg_st_r[1] == PG_HIGH && pg_cnt_r[1] == PULSE_LAST && !sec_en_r[SEC_MODE_BIT])
        |=> pg_st_r[1] == PG_IDLE)
        else $error("single pulse mode produced a gap phase");

    chk_train_repeats: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (pg_st_r[1] == PG_GAP && pg_cnt_r[1] == PERIOD_LAST && train_r[1])
        |=> second_irq_output_o && pg_cnt_r[1] == '0)
        else $error("pulse train did not repeat on period");

    chk_range_first: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (pg_st_r[0] == PG_IDLE && ev_out_of_range_i && comb_ctrl_r[COMB_RANGE1_BIT - COMB_CTRL_LSB])
        |=> first_irq_output_o)
        else $error("out-of-range event did not reach first irq");

    chk_gpo_level: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (pin_func == PF_GPO && !wr_pin) |=> (!multi_purpose_pin_oe_n_o
         && multi_purpose_pin_out_o == $past(pin_ctrl_r[PIN_GPO_BIT])))
        else $error("pin does not show general output value");

    chk_pin_off: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (pin_func == PF_OFF && !wr_pin) |=> multi_purpose_pin_oe_n_o)
        else $error("pin driven while powered down");

    chk_pen_status: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (reg_rd_i && reg_addr_i == ADDR_COMBINED) |=> reg_rdata_o[COMB_PEN_BIT] == $past(pen_touch_i))
        else $error("pen touch status not returned");

    chk_sticky_clear: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (|flag_rd && !ev_headset_insert_i) |=> !sticky_flags_o[6])
        else $error("sticky flag not cleared on read");

    chk_sticky_set: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        ev_headset_insert_i |=> sticky_flags_o[6])
        else $error("sticky flag lost an event");

    chk_sec_gate: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (pg_st_r[1] == PG_IDLE && |(sec_ev & sec_en_r[7:1]))
        |=> second_irq_output_o)
        else $error("enabled audio event did not start second irq");

    chk_touch_first: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (pg_st_r[0] == PG_IDLE && ev_touch_data_i && comb_ctrl_r[COMB_DATA1_BIT - COMB_CTRL_LSB])
        |=> first_irq_output_o)
        else $error("touch data event did not reach first irq");

    chk_range_second: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (pg_st_r[1] == PG_IDLE && ev_out_of_range_i && comb_ctrl_r[COMB_RANGE2_BIT - COMB_CTRL_LSB])
        |=> second_irq_output_o)
        else $error("out-of-range event did not reach second irq");

    chk_train_stops: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (pg_st_r[1] == PG_GAP && pg_cnt_r[1] == PERIOD_LAST && !train_r[1])
        |=> !second_irq_output_o)
        else $error("pulse train went on after the flag reads");

    chk_meas_status: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (reg_rd_i && reg_addr_i == ADDR_COMBINED)
        |=> reg_rdata_o[COMB_AVAIL_BIT] == $past(meas_data_ready_i)
            && reg_rdata_o[COMB_OUTR_BIT] == $past(meas_out_of_range_i))
        else $error("measurement status not returned");

    chk_in_buf_read: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (reg_rd_i && reg_addr_i == ADDR_PIN_CTRL && pin_func != PF_OFF)
        |=> reg_rdata_o[PIN_IN_BIT] == $past(pin_sync_r))
        else $error("pin input buffer not returned");

    chk_pin_irq1: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (pin_func == PF_IRQ1)
        |=> !multi_purpose_pin_oe_n_o && multi_purpose_pin_out_o == $past(first_irq_output_o))
        else $error("pin does not follow first irq");

    chk_pin_divided_clock_output: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (pin_func == PF_DIVIDED_CLOCK_OUTPUT)
        |=> !multi_purpose_pin_oe_n_o && multi_purpose_pin_out_o == $past(divided_clock_output_i))
        else $error("pin does not follow divided clock");

    chk_pin_touch: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (pin_func == PF_TOUCH_IRQ)
        |=> !multi_purpose_pin_oe_n_o && multi_purpose_pin_out_o == $past(touch_data_ready_irq_n_i))
        else $error("pin does not follow touch irq");

endmodule : irq_pin_router

`default_nettype wire

// File: src/irq_router_pkg.sv
// Purpose: constants and types for the interrupt routing and multi-purpose pin block
// Assumes: one 250 MHz clock, byte-wide register port at the printed offsets
// Notes: times are kept in ms and turned into cycle counts here
package irq_router_pkg;

    localparam int CLK_KHZ = 250000;
    localparam int PULSE_MS = 2;
    localparam int PERIOD_MS = 4;
    localparam int PULSE_CYC = PULSE_MS * CLK_KHZ;
    localparam int PERIOD_CYC = PERIOD_MS * CLK_KHZ;

    localparam logic [7:0] ADDR_FLAGS_A = 8'h2c;
    localparam logic [7:0] ADDR_FLAGS_B = 8'h2d;
    localparam logic [7:0] ADDR_SEC_EN = 8'h31;
    localparam logic [7:0] ADDR_COMBINED = 8'h32;
    localparam logic [7:0] ADDR_PIN_CTRL = 8'h33;

    localparam logic [7:0] SEC_EN_RESET = 8'h00;
    localparam logic [3:0] COMB_CTRL_RESET = 4'h0;
    localparam logic [7:0] PIN_CTRL_RESET = 8'h00;

    localparam int SEC_MODE_BIT = 0;
    localparam int COMB_RANGE1_BIT = 7;
    localparam int COMB_DATA1_BIT = 6;
    localparam int COMB_RANGE2_BIT = 5;
    localparam int COMB_CTRL_LSB = 4;
    localparam int COMB_PEN_BIT = 3;
    localparam int COMB_AVAIL_BIT = 2;
    localparam int COMB_OUTR_BIT = 1;
    localparam int PIN_RSV_LSB = 6;
    localparam int PIN_FUNC_LSB = 2;
    localparam int PIN_FUNC_MSB = 5;
    localparam int PIN_IN_BIT = 1;
    localparam int PIN_GPO_BIT = 0;
    localparam int NUM_EVENTS = 9;

    typedef enum logic [3:0] {
        PF_OFF = 4'h0,
        PF_IN = 4'h1,
        PF_GPI = 4'h2,
        PF_GPO = 4'h3,
        PF_DIVIDED_CLOCK_OUTPUT = 4'h4,
        PF_IRQ1 = 4'h5,
        PF_IRQ2 = 4'h6,
        PF_REC_WCLK = 4'h7,
        PF_SEC_BCLK = 4'h8,
        PF_SEC_WCLK = 4'h9,
        PF_MIC_CLK = 4'ha,
        PF_SEC_SOUT = 4'hb,
        PF_TOUCH_IRQ = 4'hc
    } pin_func_t;

    typedef enum logic [2:0] {
        PG_IDLE = 3'b001,
        PG_HIGH = 3'b010,
        PG_GAP = 3'b100
    } pulse_state_t;

endpackage : irq_router_pkg

// File: test/irq_host_model.sv
// Purpose: host-side model that watches both irq lines and shares the multi-purpose pin
// Assumes: irq lines are sampled on mclk_i rising edges
// Notes: the host drives the pin only while the block has released it
`timescale 1ns/1ps
`default_nettype none

module irq_host_model (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic irq1_i,
    input wire logic irq2_i,
    input wire logic pin_out_i,
    input wire logic pin_oe_n_i,
    input wire logic host_level_i,
    output logic pin_level_o,
    output logic [15:0] rise1_o,
    output logic [15:0] rise2_o,
    output logic [15:0] high2_o
);
    logic irq1_d_r;
    logic irq2_d_r;

    // no contention: the host level only reaches the wire while oe_n is high
    assign pin_level_o = pin_oe_n_i ? host_level_i : pin_out_i;

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            irq1_d_r <= 1'b0;
            irq2_d_r <= 1'b0;
            rise1_o <= 16'h0;
            rise2_o <= 16'h0;
            high2_o <= 16'h0;
        end else begin
            irq1_d_r <= irq1_i;
            irq2_d_r <= irq2_i;
            rise1_o <= rise1_o + 16'(irq1_i && !irq1_d_r);
            rise2_o <= rise2_o + 16'(irq2_i && !irq2_d_r);
            high2_o <= high2_o + 16'(irq2_i);
        end
    end
endmodule : irq_host_model

`default_nettype wire

// File: test/test_codec_irq_routing_and_pin_mux.sv
// Purpose: self-checking bench for irq routing and multi-purpose pin muxing
// Assumes: short pulse and period counts so that trains fit a short run
// Notes: all stimulus changes 1 ns after a rising edge
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fails++; \
    $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); end end

module test_codec_irq_routing_and_pin_mux;
    import irq_router_pkg::*;
    localparam int PULSE = 20;
    localparam int PERIOD = 40;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [8:0] ev = 9'h0;
    logic [2:0] stat = 3'b000;
    logic [6:0] src = 7'h00;
    logic host_lvl = 1'b0;
    logic [7:0] rdata;
    logic pin_lvl, pin_out, pin_oe_n, pin_in, general_purpose_input, irq1, irq2;
    logic [8:0] sticky;
    logic [15:0] r1, r2, h2, base2;
    logic [1:0] e;
    int fails = 0;
    int checks_done = 0;

    initial begin
        forever #2 clk = ~clk;
    end

    irq_pin_router #(.PULSE_CYCLES(PULSE), .PERIOD_CYCLES(PERIOD)) u_irq_pin_router (
        .mclk_i(clk), .reset_n_i(rst_n), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .ev_headset_insert_i(ev[6]),
        .ev_button_press_i(ev[5]), .ev_drc_power_i(ev[4]), .ev_agc_noise_i(ev[3]),
        .ev_short_circuit_i(ev[2]), .ev_engine_i(ev[1]), .ev_dc_meas_ready_i(ev[0]),
        .ev_out_of_range_i(ev[7]), .ev_touch_data_i(ev[8]), .pen_touch_i(stat[2]),
        .meas_data_ready_i(stat[1]), .meas_out_of_range_i(stat[0]), .divided_clock_output_i(src[0]),
        .record_word_clock_i(src[1]), .sec_bit_clock_i(src[2]), .sec_word_clock_i(src[3]),
        .microphone_modulator_clock_i(src[4]), .sec_audio_serial_out_i(src[5]),
        .touch_data_ready_irq_n_i(src[6]), .multi_purpose_pin_in_i(pin_lvl),
        .multi_purpose_pin_out_o(pin_out), .multi_purpose_pin_oe_n_o(pin_oe_n), .pin_input_o(pin_in),
        .general_purpose_input_o(general_purpose_input), .first_irq_output_o(irq1), .second_irq_output_o(irq2),
        .sticky_flags_o(sticky));

    irq_host_model u_irq_host_model (
        .mclk_i(clk), .reset_n_i(rst_n), .irq1_i(irq1), .irq2_i(irq2), .pin_out_i(pin_out),
        .pin_oe_n_i(pin_oe_n), .host_level_i(host_lvl), .pin_level_o(pin_lvl),
        .rise1_o(r1), .rise2_o(r2), .high2_o(h2));

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
        tick(1);
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] x);
        addr = a;
        rd = 1'b1;
        tick(1);
        rd = 1'b0;
        `CHK(rdata, x)
        tick(1);
    endtask : rd_chk

    // one event pulse, then the whole single-pulse window is watched
    task automatic fire(input int i, input logic e1, input logic e2);
        logic [15:0] a1, a2, b2;
        a1 = r1;
        a2 = r2;
        b2 = h2;
        ev[i] = 1'b1;
        tick(1);
        ev[i] = 1'b0;
        `CHK(({irq1, irq2}), ({e1, e2}))
        tick(PERIOD + PULSE);
        `CHK(r1 - a1, 16'(e1))
        `CHK(r2 - a2, 16'(e2))
        `CHK(h2 - b2, e2 ? 16'(PULSE) : 16'h0)
    endtask : fire

    function automatic logic [1:0] pin_exp(input int c, input logic p);
        if (c == 3) return {1'b0, p};
        if (c == 5 || c == 6) return 2'b00;
        if (c == 4 || (c > 6 && c < 13)) return {1'b0, src[c == 4 ? 0 : c - 6]};
        return 2'b10;
    endfunction : pin_exp

    initial begin
        #100000;
        fails++;
        tally_and_finish();
    end

    initial begin
        tick(12);
        rst_n = 1'b1;
        tick(1);
        `CHK(({irq1, irq2, pin_oe_n, sticky}), 12'h200)
        rd_chk(ADDR_SEC_EN, SEC_EN_RESET);
        rd_chk(ADDR_COMBINED, 8'h00);
        rd_chk(ADDR_PIN_CTRL, PIN_CTRL_RESET);
        for (int i = 0; i < 9; i++) begin
            fire(i, 1'b0, 1'b0);
        end
        wr_reg(ADDR_SEC_EN, 8'ha5);
        rd_chk(ADDR_SEC_EN, 8'ha5);
        wr_reg(8'h40, 8'hff);
        rd_chk(8'h40, 8'h00);
        stat = 3'b101;
        wr_reg(ADDR_COMBINED, 8'hff);
        rd_chk(ADDR_COMBINED, 8'hfa);
        stat = 3'b010;
        rd_chk(ADDR_COMBINED, 8'hf4);
        stat = 3'b000;
        wr_reg(ADDR_COMBINED, 8'h00);
        for (int b = 1; b < 8; b++) begin
            wr_reg(ADDR_SEC_EN, 8'(1 << b));
            fire(b - 1, 1'b0, 1'b1);
            fire(b % 7, 1'b0, 1'b0);
        end
        wr_reg(ADDR_SEC_EN, 8'h00);
        wr_reg(ADDR_COMBINED, 8'h80);
        fire(7, 1'b1, 1'b0);
        fire(8, 1'b0, 1'b0);
        wr_reg(ADDR_COMBINED, 8'h40);
        fire(8, 1'b1, 1'b0);
        fire(7, 1'b0, 1'b0);
        wr_reg(ADDR_COMBINED, 8'h20);
        fire(7, 1'b0, 1'b1);
        fire(8, 1'b0, 1'b0);
        wr_reg(ADDR_COMBINED, 8'h00);
        // pulse train keeps running until all three flag reads are seen
        wr_reg(ADDR_SEC_EN, 8'h81);
        rd_chk(ADDR_FLAGS_A, 8'h00);
        `CHK(sticky, 9'h0)
        base2 = r2;
        ev[6] = 1'b1;
        tick(1);
        ev[6] = 1'b0;
        `CHK(sticky, 9'h040)
        tick(3 * PERIOD - 12);
        `CHK(r2 - base2, 16'd3)
        rd_chk(ADDR_FLAGS_A, 8'h00);
        rd_chk(ADDR_FLAGS_B, 8'h00);
        rd_chk(ADDR_COMBINED, 8'h00);
        `CHK(sticky, 9'h0)
        tick(3 * PERIOD);
        `CHK(r2 - base2, 16'd3)
        wr_reg(ADDR_SEC_EN, 8'h00);
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < 16; c++) begin
                host_lvl = p[0];
                src = p[0] ? 7'h29 : 7'h56;
                wr_reg(ADDR_PIN_CTRL, {2'b00, c[3:0], 1'b0, p[0]});
                tick(4);
                e = pin_exp(c, p[0]);
                `CHK(pin_oe_n, e[1])
                if (c == 0 || c > 2) begin
                    `CHK(pin_out, e[0])
                end
                `CHK(({pin_in, general_purpose_input}), ({c == 1 && p[0], c == 2 && p[0]}))
                rd_chk(ADDR_PIN_CTRL, {2'b00, c[3:0], c != 0 && (e[1] ? p[0] : e[0]), p[0]});
            end
        end
        // the pin can carry the first irq out of the block
        wr_reg(ADDR_PIN_CTRL, 8'h14);
        wr_reg(ADDR_COMBINED, 8'h40);
        ev[8] = 1'b1;
        tick(1);
        ev[8] = 1'b0;
        tick(1);
        `CHK(({pin_oe_n, pin_out}), 2'b01)
        tick(PERIOD);
        `CHK(({pin_oe_n, pin_out}), 2'b00)
        tally_and_finish();
    end
endmodule : test_codec_irq_routing_and_pin_mux

`default_nettype wire
